// ### rtl/sie_status_encoder.sv
`timescale 1ns/1ps
// Behaviour
// (RULE_01) Idle and searching: pin statically high.
// (RULE_02) Pin low throughout each received frame.
// (RULE_03) Low-power sleep: pin statically low.
// (RULE_04) Transmitting: pin toggles each transmission interval.
// (RULE_05) Tool link: pin toggles every second.
// (RULE_06) Commands enabled, setting off: toggle 500 ms.
// (RULE_07) Fault: toggle 250 ms, keep fault codes.
// (RULE_08) Host enters command mode with paced pluses.
// (RULE_09) Priority: fault, sleep, command, tool, transmit, receive.
module sie_status_encoder #(
    parameter int TOOL_CYC = sie_pkg::TOOL_CYC,
    parameter int CMD_CYC = sie_pkg::CMD_CYC,
    parameter int FAULT_CYC = sie_pkg::FAULT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Module state indications, same clock domain
    input wire logic rx_frame,
    input wire logic tx_active,
    input wire logic tx_tick,
    input wire logic low_power_sleep_state,
    input wire logic tool_link,
    input wire logic text_config_commands,
    input wire logic text_config_command_setting,
    input wire logic fault,
    input wire logic [sie_pkg::FAULT_CODE_W-1:0] fault_code,
    input wire logic fault_codes_clear,
    // Status pin and fault code readout
    output logic stat_out,
    output logic [sie_pkg::FAULT_CODE_W-1:0] fault_codes,
    output logic [2:0] mode_out
);
    import sie_pkg::*;

    // The counter must hold the longest period.
    localparam int CNT_W = $clog2(TOOL_CYC + 1);
    localparam logic [CNT_W-1:0] TOOL_LAST = CNT_W'(TOOL_CYC - 1);
    localparam logic [CNT_W-1:0] CMD_LAST = CNT_W'(CMD_CYC - 1);
    localparam logic [CNT_W-1:0] FAULT_LAST = CNT_W'(FAULT_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    sie_mode_e mode;
    sie_mode_e sel_mode;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] blink_last;
    logic next_stat;
    logic mode_chg;
    logic period_hit;
    logic is_blink;
    logic cmd_blink;
    logic code_event;
    logic [FAULT_CODE_W-1:0] next_codes;

    // The command blink applies only when the text command setting is off
    // and the commands were switched on by the paced plus sequence.
    assign cmd_blink = text_config_commands // RULE_06
                       & ~text_config_command_setting;

    // Fixed priority; a fault must stay visible whatever else is going on.
    assign sel_mode = fault ? SIE_FAULT : // RULE_09
                      low_power_sleep_state ? SIE_SLEEP :
                      cmd_blink ? SIE_CMD :
                      tool_link ? SIE_TOOL :
                      tx_active ? SIE_TX :
                      rx_frame ? SIE_RX :
                      SIE_IDLE;

    assign mode_chg = sel_mode != mode;

    assign blink_last = (mode == SIE_FAULT) ? FAULT_LAST : // RULE_07
                        (mode == SIE_CMD) ? CMD_LAST : // RULE_06
                        TOOL_LAST; // RULE_05

    assign is_blink = (mode == SIE_FAULT) | (mode == SIE_CMD) |
                      (mode == SIE_TOOL);

    assign period_hit = is_blink & (cnt == blink_last);

    // A blink period restarts on every mode change, so the first toggle
    // after entering a blink mode comes one full period later.
    always_comb begin
        unique case (mode)
            SIE_IDLE: next_stat = STAT_IDLE_LEVEL; // RULE_01
            SIE_RX: next_stat = STAT_RX_LEVEL; // RULE_02
            SIE_SLEEP: next_stat = STAT_SLEEP_LEVEL; // RULE_03
            SIE_TX: next_stat = stat_out ^ tx_tick; // RULE_04
            SIE_TOOL, SIE_CMD, SIE_FAULT: next_stat = stat_out ^ period_hit;
            default: next_stat = STAT_RESET_LEVEL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= SIE_IDLE;
            cnt <= '0;
            stat_out <= STAT_RESET_LEVEL;
        end else begin
            mode <= sel_mode;
            cnt <= (mode_chg | period_hit) ? '0 : cnt + CNT_ONE;
            stat_out <= next_stat;
        end
    end

    // Fault codes are sticky so the tool can read them after the fault
    // has gone; a new code in the clearing cycle is kept.
    assign code_event = fault & (fault_code != FAULT_CODE_RESET); // RULE_07
    assign next_codes = (fault_codes_clear ? FAULT_CODE_RESET : fault_codes)
                        | (code_event ? fault_code : FAULT_CODE_RESET);

    always_ff @(posedge clk) begin
        if (rst) begin
            fault_codes <= FAULT_CODE_RESET;
            mode_out <= 3'h0;
        end else begin
            fault_codes <= next_codes;
            mode_out <= sel_mode;
        end
    end

    // Helper for the checks below: cycles since the pin or mode last
    // changed, so a long blink period can be checked to the cycle.
    logic [CNT_W-1:0] gap;
    logic prev_stat;
    sie_mode_e prev_mode;

    always_ff @(posedge clk) begin
        if (rst) begin
            gap <= '0;
            prev_stat <= STAT_RESET_LEVEL;
            prev_mode <= SIE_IDLE;
        end else begin
            prev_stat <= stat_out;
            prev_mode <= mode;
            if (mode_chg || (next_stat != stat_out)) begin
                gap <= '0;
            end else begin
                gap <= gap + CNT_ONE;
            end
        end
    end

    a_idle_high: assert property ( // RULE_01
        @(posedge clk) disable iff (rst)
        (mode == SIE_IDLE) |=> stat_out
    ) else $error("status pin not high while idle");

    a_rx_low: assert property ( // RULE_02
        @(posedge clk) disable iff (rst)
        (rx_frame && !tx_active && !tool_link && !cmd_blink &&
         !low_power_sleep_state && !fault) |=> ##1 !stat_out
    ) else $error("status pin not low during a received frame");

    a_sleep_low: assert property ( // RULE_03
        @(posedge clk) disable iff (rst)
        (low_power_sleep_state && !fault)[*2] |=> !stat_out
    ) else $error("status pin not low while asleep");

    a_tx_toggle: assert property ( // RULE_04
        @(posedge clk) disable iff (rst)
        (mode == SIE_TX) |=> (stat_out != $past(stat_out)) == $past(tx_tick)
    ) else $error("status pin toggle does not follow transmit ticks");

    a_tool_period: assert property ( // RULE_05
        @(posedge clk) disable iff (rst)
        (mode == SIE_TOOL && prev_mode == SIE_TOOL && stat_out != prev_stat)
        |-> $past(gap) == TOOL_LAST
    ) else $error("tool link blink period wrong");

    a_cmd_period: assert property ( // RULE_06
        @(posedge clk) disable iff (rst)
        (mode == SIE_CMD && prev_mode == SIE_CMD && stat_out != prev_stat)
        |-> $past(gap) == CMD_LAST
    ) else $error("command enable blink period wrong");

    a_fault_period: assert property ( // RULE_07
        @(posedge clk) disable iff (rst)
        (mode == SIE_FAULT && prev_mode == SIE_FAULT && stat_out != prev_stat)
        |-> $past(gap) == FAULT_LAST
    ) else $error("fault blink period wrong");

    a_blink_runs: assert property ( // RULE_07
        @(posedge clk) disable iff (rst)
        (is_blink && !mode_chg && gap > blink_last) |-> 1'b0
    ) else $error("blink mode missed its toggle");

    a_fault_codes: assert property ( // RULE_07
        @(posedge clk) disable iff (rst)
        code_event |=> (fault_codes & $past(fault_code)) == $past(fault_code)
    ) else $error("fault code lost");

    a_fault_first: assert property ( // RULE_09
        @(posedge clk) disable iff (rst)
        fault |=> mode == SIE_FAULT
    ) else $error("fault did not take priority");

    a_sleep_over_cmd: assert property ( // RULE_09
        @(posedge clk) disable iff (rst)
        (low_power_sleep_state && !fault && (cmd_blink || tool_link))
        |=> mode == SIE_SLEEP
    ) else $error("sleep did not take priority");

    a_rx_static: assert property ( // RULE_02
        @(posedge clk) disable iff (rst)
        (mode == SIE_RX) |=> !stat_out
    ) else $error("status pin not low in receive mode");

    a_sleep_static: assert property ( // RULE_03
        @(posedge clk) disable iff (rst)
        (mode == SIE_SLEEP) |=> !stat_out
    ) else $error("status pin not low in sleep mode");

    a_blink_steady: assert property ( // RULE_05
        @(posedge clk) disable iff (rst)
        (is_blink && !period_hit) |=> $stable(stat_out)
    ) else $error("status pin toggled inside a blink period");

    a_codes_clear: assert property ( // RULE_07
        @(posedge clk) disable iff (rst)
        (fault_codes_clear && !code_event) |=> fault_codes == FAULT_CODE_RESET
    ) else $error("fault codes not cleared");

    a_setting_on: assert property ( // RULE_06
        @(posedge clk) disable iff (rst)
        text_config_command_setting |=> mode != SIE_CMD
    ) else $error("command blink shown with the setting on");

endmodule

// ### rtl/sie_pkg.sv
package sie_pkg;

    // Core clock rate; every blink period is derived from it.
    localparam int CLK_HZ = 250_000_000;
    localparam int CLK_PER_MS = CLK_HZ / 1000;

    // Blink half-periods: time between two toggles of the status pin.
    localparam int TOOL_PERIOD_MS = 1000;
    localparam int CMD_PERIOD_MS = 500;
    localparam int FAULT_PERIOD_MS = 250;
    localparam int TOOL_CYC = TOOL_PERIOD_MS * CLK_PER_MS;
    localparam int CMD_CYC = CMD_PERIOD_MS * CLK_PER_MS;
    localparam int FAULT_CYC = FAULT_PERIOD_MS * CLK_PER_MS;

    // Static levels of the status pin.
    localparam logic STAT_IDLE_LEVEL = 1'b1;
    localparam logic STAT_RX_LEVEL = 1'b0;
    localparam logic STAT_SLEEP_LEVEL = 1'b0;
    localparam logic STAT_RESET_LEVEL = 1'b1;

    // Fault code field.
    localparam int FAULT_CODE_W = 8;
    localparam logic [FAULT_CODE_W-1:0] FAULT_CODE_RESET = 8'h00;

    // Indicated modes, Gray coded along the usual priority order.
    typedef enum logic [2:0] {
        SIE_IDLE = 3'h0,
        SIE_RX = 3'h1,
        SIE_TX = 3'h3,
        SIE_TOOL = 3'h2,
        SIE_CMD = 3'h6,
        SIE_SLEEP = 3'h7,
        SIE_FAULT = 3'h5
    } sie_mode_e;

endpackage

// ### test/sie_led_model.sv
`timescale 1ns/1ps
// Host input watching the status pin; it times every change of level.
module sie_led_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Status pin as the host sees it
    input wire logic stat_in,
    // One-cycle report of a level change and the cycles since the last one
    output logic edge_seen,
    output logic [15:0] gap
);
    logic last;
    logic [15:0] count;
    always_ff @(posedge clk) begin
        if (rst) begin
            last <= 1'b1;
            count <= 16'h0000;
            edge_seen <= 1'b0;
            gap <= 16'h0000;
        end else begin
            last <= stat_in;
            edge_seen <= (stat_in !== last);
            if (stat_in !== last) begin
                gap <= count + 16'h0001;
                count <= 16'h0000;
            end else begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule

// ### test/sie_status_encoder_bench.sv
`timescale 1ns/1ps
module sie_status_encoder_bench;
    import sie_pkg::*;
    localparam int PER[3] = '{40, 20, 10};
    localparam sie_mode_e MD[3] = '{SIE_TOOL, SIE_CMD, SIE_FAULT};
    logic clk = 1'b0, rst = 1'b1, rx = 1'b0, txa = 1'b0, tick = 1'b0;
    logic slp = 1'b0, tool = 1'b0, cmd = 1'b0, set = 1'b0, flt = 1'b0;
    logic clr = 1'b0, stat_out, edge_seen;
    logic [7:0] code = 8'h00, codes, c;
    logic [2:0] mode_out;
    logic [15:0] gap;
    int bad_count = 0, tests_run = 0, e, g, expq[$];
    always #2 clk = ~clk;
    sie_status_encoder #(.TOOL_CYC(40), .CMD_CYC(20), .FAULT_CYC(10))
        i_sie_status_encoder (.clk(clk), .rst(rst), .rx_frame(rx),
        .tx_active(txa), .tx_tick(tick), .low_power_sleep_state(slp),
        .tool_link(tool), .text_config_commands(cmd),
        .text_config_command_setting(set), .fault(flt), .fault_code(code),
        .fault_codes_clear(clr), .stat_out(stat_out), .fault_codes(codes),
        .mode_out(mode_out));
    sie_led_model i_sie_led_model (.clk(clk), .rst(rst), .stat_in(stat_out),
        .edge_seen(edge_seen), .gap(gap));
    task check(input string what, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task drain;
        for (int i = 0; i < 600 && expq.size() > 0; i++) @(posedge clk);
        check("toggles left", 16'(expq.size()), 16'h0000);
    endtask
    // Every change of the pin must have a note; -1 marks an untimed one.
    always @(negedge clk) begin
        if (edge_seen === 1'b1 && expq.size() == 0) begin
            check("stray toggle", 16'h1, 16'h0);
        end else if (edge_seen === 1'b1) begin
            e = expq.pop_front();
            if (e >= 0) begin
                check("gap", gap, 16'(e));
            end
        end
    end
    initial begin
        #(4 * 20000);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h87AD));
        settle(3);
        rst <= 1'b0;
        settle(3);
        check("idle level", 16'(stat_out), 16'h1);
        expq.push_back(-1);
        rx <= 1'b1;
        settle(60);
        check("rx level", 16'(stat_out), 16'(STAT_RX_LEVEL));
        expq.push_back(-1);
        rx <= 1'b0;
        settle(3);
        drain;
        expq.push_back(-1);
        {slp, rx, tool} <= 3'h7;
        settle(100);
        check("sleep level", 16'(stat_out), 16'h0);
        check("sleep mode", 16'(mode_out), 16'(SIE_SLEEP));
        expq.push_back(-1);
        {slp, rx, tool} <= 3'h0;
        settle(3);
        drain;
        txa <= 1'b1;
        expq.push_back(-1);
        for (int i = 0; i < 4; i++) begin
            g = 2 + $urandom % 6;
            if (i > 0) expq.push_back(g);
            repeat (g - 1) @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        drain;
        txa <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            c = 8'($urandom);
            tool <= 1'b1;
            // The enable stands for an accepted paced plus sequence.
            cmd <= (m > 0);
            {flt, slp} <= {2{m == 2}};
            code <= c;
            expq.push_back(-1);
            repeat (3) expq.push_back(PER[m]);
            drain;
            check("blink mode", 16'(mode_out), 16'(MD[m]));
            {tool, cmd, flt, slp} <= 4'h0;
            settle(3);
        end
        check("fault codes", 16'(codes), 16'(c));
        code <= ~c;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        settle(2);
        check("codes cleared", 16'(codes), 16'h0);
        {flt, clr} <= 2'h3;
        code <= 8'h5A;
        @(posedge clk);
        {flt, clr} <= 2'h0;
        settle(2);
        check("set over clear", 16'(codes), 16'h5A);
        {cmd, set} <= 2'h3;
        settle(50);
        check("setting on", 16'(mode_out), 16'(SIE_IDLE));
        tally_and_finish;
    end
endmodule
